// >>> tb/pmbus_dual_slave_asserts.sv
// concurrent checks on the ports of the dual-port bus slave
`timescale 1ns/1ps
module pmbus_dual_slave_asserts #(
	parameter int STRETCH_CYCLES = 200,
	parameter int LOCKUP_CYCLES = 300,
	parameter int IDLE_CYCLES = 2000
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire pmbus_slave_pkg::pin_type [1:0] bus_in,
	input wire pmbus_slave_pkg::pin_type [1:0] bus_out,
	input wire pmbus_slave_pkg::pin_type [1:0] bus_oe,
	input wire logic [6:0] dev_addr,
	input wire logic ctrl_sel,
	input wire logic cmd_supported,
	input wire logic value_in_range,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic state_change,
	input wire logic [7:0] cur_cmd,
	input wire logic rd_req,
	input wire logic wr_valid,
	input wire pmbus_slave_pkg::wr_type wr,
	input wire pmbus_slave_pkg::flags_type status,
	input wire logic ctrl_port,
	input wire logic [1:0] alert_n
);
	int st_cnt;
	int lk_cnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// cycles of our own clock stretch, cleared as soon as both ports let go
	always_ff @(posedge clk or negedge reset_n)
		st_cnt <= !reset_n ? 0 : (bus_oe[0].scl || bus_oe[1].scl) ? st_cnt + 1 : 0;
	// cycles port 0 is held low by someone else; our own ack or stretch does not count
	always_ff @(posedge clk or negedge reset_n)
		lk_cnt <= !reset_n ? 0 : ((!bus_in[0].scl && !bus_oe[0].scl) ||
			(!bus_in[0].sda && !bus_oe[0].sda)) ? lk_cnt + 1 : 0;
	sequence alert_low_s;
		##[0:2] alert_n == 2'h0;
	endsequence
	drive_low_a: assert property (bus_out == '0)
		else $error("pin driven high");
	stretch_cause_a: assert property (($rose(bus_oe[0].scl) || $rose(bus_oe[1].scl)) |->
		(rd_req || $past(rd_req))) else $error("stretch without read request");
	stretch_cap_a: assert property (st_cnt <= STRETCH_CYCLES + 4)
		else $error("stretch too long");
	lockup_drop_a: assert property (lk_cnt > LOCKUP_CYCLES + 8 |->
		bus_oe[0] == '0 && status.comm_error) else $error("lock-up not abandoned");
	unsup_alert_a: assert property ($rose(status.unsupported) |-> alert_low_s)
		else $error("unsupported without attention");
	range_alert_a: assert property ($rose(status.out_of_range) |-> alert_low_s)
		else $error("range fault without attention");
	pec_alert_a: assert property ($rose(status.pec_error) |-> alert_low_s)
		else $error("check byte fault without attention");
	change_alert_a: assert property (state_change |-> alert_low_s)
		else $error("state change without attention");
	ctrl_track_a: assert property ($stable(ctrl_sel) [*2] |-> ctrl_port == ctrl_sel)
		else $error("control port wrong");
endmodule
bind pmbus_dual_slave pmbus_dual_slave_asserts #(.STRETCH_CYCLES(STRETCH_CYCLES),
	.LOCKUP_CYCLES(LOCKUP_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)) pmbus_dual_slave_asserts_i (
	.clk(clk), .reset_n(reset_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
	.dev_addr(dev_addr), .ctrl_sel(ctrl_sel), .cmd_supported(cmd_supported),
	.value_in_range(value_in_range), .rd_data(rd_data), .rd_valid(rd_valid),
	.state_change(state_change), .cur_cmd(cur_cmd), .rd_req(rd_req), .wr_valid(wr_valid),
	.wr(wr), .status(status), .ctrl_port(ctrl_port), .alert_n(alert_n));

// >>> tb/pmbus_dual_slave_tb.sv
// bench: random writes and reads, faults, clears on both ports, lock-up
`timescale 1ns/1ps
module pmbus_dual_slave_tb;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	pmbus_slave_pkg::pin_type [1:0] bus_in, bus_out, bus_oe;
	logic [1:0] scl_lv, sda_lv, scl_pull, sda_pull, alert_n;
	logic [6:0] dev_addr;
	logic ctrl_sel;
	logic cmd_supported;
	logic value_in_range;
	logic [15:0] rd_data;
	logic rd_valid = 1'h0;
	logic state_change;
	logic [7:0] cur_cmd;
	logic rd_req, wr_valid, ctrl_port;
	int wr_cnt = 0;
	pmbus_slave_pkg::wr_type wr, wr_cap;
	pmbus_slave_pkg::flags_type status;
	logic [3:0] ef = 4'h0;
	int failures = 0;
	int check_count = 0;
	initial
		forever #20 clk = ~clk;
	// pulled-up wires: low while any party pulls
	always_comb
		for (int k = 0; k < 2; k++)
		begin
			scl_lv[k] = !(scl_pull[k] || bus_oe[k].scl);
			sda_lv[k] = !(sda_pull[k] || bus_oe[k].sda);
			bus_in[k] = {scl_lv[k], sda_lv[k]};
		end
	pmbus_dual_slave #(.STRETCH_CYCLES(200), .LOCKUP_CYCLES(300), .IDLE_CYCLES(2000))
		pmbus_dual_slave_i (.clk(clk), .reset_n(reset_n), .bus_in(bus_in), .bus_out(bus_out),
		.bus_oe(bus_oe), .dev_addr(dev_addr), .ctrl_sel(ctrl_sel), .cmd_supported(cmd_supported),
		.value_in_range(value_in_range), .rd_data(rd_data), .rd_valid(rd_valid),
		.state_change(state_change), .cur_cmd(cur_cmd), .rd_req(rd_req), .wr_valid(wr_valid),
		.wr(wr), .status(status), .ctrl_port(ctrl_port), .alert_n(alert_n));
	pmbus_host_model pmbus_host_model_i (.clk(clk), .scl_lv(scl_lv), .sda_lv(sda_lv),
		.scl_pull(scl_pull), .sda_pull(sda_pull));
	// user side answers a read one cycle later; write pulses are counted
	always @(negedge clk)
		rd_valid <= rd_req;
	always @(posedge clk)
		if (wr_valid)
		begin
			wr_cnt <= wr_cnt + 1;
			wr_cap <= wr;
		end
	function automatic logic [7:0] pec(input logic [7:0] b[5], input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++)
		begin
			c = c ^ b[i];
			for (int j = 0; j < 8; j++)
				c = c[7] ? {c[6:0], 1'h0} ^ 8'h07 : {c[6:0], 1'h0};
		end
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// write frame of n data bytes; bad flips the check byte
	task automatic xfer(input int p, input logic [7:0] c, input logic [15:0] d, input int n,
		input logic bad);
		logic [7:0] b[5];
		logic k;
		b = '{{dev_addr, 1'h0}, c, d[7:0], d[15:8], 8'h00};
		b[n + 2] = pec(b, n + 2) ^ {7'h00, bad};
		pmbus_host_model_i.start(p);
		for (int i = 0; i < n + 3; i++)
		begin
			pmbus_host_model_i.wbyte(p, b[i], k);
			if (i == 0)
				chk(k, 1'h0);
		end
		pmbus_host_model_i.stop(p);
		repeat (10) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] exp);
		logic [7:0] b[5];
		logic [7:0] lo, hi, pc;
		logic k;
		b = '{{dev_addr, 1'h0}, c, {dev_addr, 1'h1}, exp[7:0], exp[15:8]};
		pmbus_host_model_i.start(0);
		pmbus_host_model_i.wbyte(0, b[0], k);
		pmbus_host_model_i.wbyte(0, c, k);
		pmbus_host_model_i.start(0);
		pmbus_host_model_i.wbyte(0, b[2], k);
		pmbus_host_model_i.rbyte(0, 1'h0, lo);
		pmbus_host_model_i.rbyte(0, 1'h0, hi);
		pmbus_host_model_i.rbyte(0, 1'h1, pc);
		pmbus_host_model_i.stop(0);
		chk({hi, lo}, exp);
		chk(pc, pec(b, 5));
		repeat (10) @(negedge clk);
	endtask
	// alert response query on port 0: the unit must send its own address
	task automatic ara(input logic [7:0] exp);
		logic [7:0] b[5];
		logic [7:0] a, pc;
		logic k;
		b = '{8'h19, exp, 8'h00, 8'h00, 8'h00};
		pmbus_host_model_i.start(0);
		pmbus_host_model_i.wbyte(0, b[0], k);
		pmbus_host_model_i.rbyte(0, 1'h0, a);
		pmbus_host_model_i.rbyte(0, 1'h1, pc);
		pmbus_host_model_i.stop(0);
		chk(a, exp);
		chk(pc, pec(b, 2));
		repeat (10) @(negedge clk);
	endtask
	initial
	begin
		logic [7:0] c;
		logic [15:0] d;
		int m;
		int w0;
		void'($urandom(32'h46D80DF8));
		dev_addr = {1'h1, 6'($urandom)};
		ctrl_sel = 1'h0;
		cmd_supported = 1'h1;
		value_in_range = 1'h1;
		rd_data = 16'($urandom);
		state_change = 1'h0;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		repeat (4) @(negedge clk);
		chk(alert_n, 2'h0);
		chk(bus_oe, 4'h0);
		// the first four frames walk every outcome once, the rest are drawn
		for (int i = 0; i < 8; i++)
		begin
			m = (i < 4) ? i : $urandom % 4;
			c = 8'h20 | 8'($urandom % 32);
			d = 16'($urandom);
			cmd_supported = (m != 1);
			value_in_range = (m != 2);
			w0 = wr_cnt;
			xfer(0, c, d, 2, m == 3);
			ef = ef | ((m == 0) ? 4'h0 : 4'h1 << (4 - m));
			chk(status, ef);
			chk(wr_cnt - w0, m == 0);
			chk(cur_cmd, c);
			if (m == 0)
				chk(wr_cap, {c, d[7:0], d[15:8], 2'h2});
		end
		chk(alert_n, 2'h0);
		cmd_supported = 1'h1;
		xfer(1, pmbus_slave_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0, 1'h0);
		chk({status, alert_n}, {ef, 2'h0});
		xfer(0, pmbus_slave_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0, 1'h0);
		chk({status, alert_n}, 6'h03);
		state_change = 1'h1;
		@(negedge clk);
		state_change = 1'h0;
		repeat (3) @(negedge clk);
		chk(alert_n, 2'h0);
		rd_data = 16'($urandom);
		rd(8'h21, rd_data);
		cmd_supported = 1'h0;
		rd(8'h22, 16'h0000);
		ctrl_sel = 1'h1;
		cmd_supported = 1'h1;
		xfer(1, pmbus_slave_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0, 1'h0);
		chk({ctrl_port, status, alert_n}, 7'h43);
		pmbus_host_model_i.hold_low(0, 400);
		chk(status, 4'h1);
		ara({dev_addr, 1'h1});
		chk(alert_n, 2'h2);
		print_verdict();
	end
	// hang guard, well above the few thousand cycles the sequence needs
	initial
	begin
		repeat (60000) @(negedge clk);
		failures++;
		print_verdict();
	end
endmodule

// >>> tb/pmbus_host_model.sv
// host controller model for both ports: open-drain pulls, 8-cycle bit time
`timescale 1ns/1ps
module pmbus_host_model
(
	input wire logic clk,
	input wire logic [1:0] scl_lv,
	input wire logic [1:0] sda_lv,
	output logic [1:0] scl_pull,
	output logic [1:0] sda_pull
);
	initial
	begin
		scl_pull = 2'h0;
		sda_pull = 2'h0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	// start or repeated start; waits first so a slave ack has been let go
	task automatic start(input int p);
		sda_pull[p] = 1'h0;
		w(4);
		scl_pull[p] = 1'h0;
		w(2);
		sda_pull[p] = 1'h1;
		w(2);
		scl_pull[p] = 1'h1;
		w(2);
	endtask
	task automatic stop(input int p);
		sda_pull[p] = 1'h1;
		w(2);
		scl_pull[p] = 1'h0;
		w(2);
		sda_pull[p] = 1'h0;
		w(4);
	endtask
	// one bit: data changes mid-low, sampled just before the fall
	task automatic clk_bit(input int p, input logic b, output logic r);
		w(2);
		sda_pull[p] = !b;
		w(2);
		scl_pull[p] = 1'h0;
		wait (scl_lv[p]);
		w(4);
		r = sda_lv[p];
		scl_pull[p] = 1'h1;
	endtask
	task automatic wbyte(input int p, input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(p, d[i], r);
		clk_bit(p, 1'h1, ack);
	endtask
	task automatic rbyte(input int p, input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(p, 1'h1, d[i]);
		clk_bit(p, last, r);
	endtask
	task automatic hold_low(input int p, input int n);
		sda_pull[p] = 1'h1;
		w(n);
		sda_pull[p] = 1'h0;
		w(8);
	endtask
endmodule

// >>> verilog/pmbus_dual_slave.sv
// dual-port bus slave engine with check byte, stretching, lock-up abort and attention latch
`timescale 1ns/1ps
module pmbus_dual_slave #(
	parameter int STRETCH_CYCLES = pmbus_slave_pkg::STRETCH_CYC,
	parameter int LOCKUP_CYCLES = pmbus_slave_pkg::LOCKUP_CYC,
	parameter int IDLE_CYCLES = pmbus_slave_pkg::IDLE_CYC
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire pmbus_slave_pkg::pin_type [1:0] bus_in,
	output pmbus_slave_pkg::pin_type [1:0] bus_out,
	output pmbus_slave_pkg::pin_type [1:0] bus_oe,
	input wire logic [6:0] dev_addr,
	input wire logic ctrl_sel,
	input wire logic cmd_supported,
	input wire logic value_in_range,
	input wire logic [15:0] rd_data,
	input wire logic rd_valid,
	input wire logic state_change,
	output logic [7:0] cur_cmd,
	output logic rd_req,
	output logic wr_valid,
	output pmbus_slave_pkg::wr_type wr,
	output pmbus_slave_pkg::flags_type status,
	output logic ctrl_port,
	output logic [1:0] alert_n
);

	typedef struct packed
	{
		pmbus_slave_pkg::pin_type [1:0] s1;
		pmbus_slave_pkg::pin_type [1:0] s2;
		pmbus_slave_pkg::pin_type [1:0] prev;
		pmbus_slave_pkg::state_type st;
		logic port;
		logic ctrl;
		logic [3:0] bit_cnt;
		logic [7:0] shreg;
		logic [2:0] rx_cnt;
		logic addr_phase;
		logic [7:0] cmd;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] crc;
		logic rw;
		logic ara;
		logic [1:0] tx_idx;
		logic sda_oe;
		logic scl_oe;
		logic alert;
		logic [1:0] sel_alert;
		logic [1:0] alert_n;
		pmbus_slave_pkg::flags_type flags;
		logic [19:0] low_cnt;
		logic [19:0] str_cnt;
		logic [26:0] idle_cnt;
		logic [5:0] reinit_cnt;
		logic wr_valid;
		pmbus_slave_pkg::wr_type wr;
		logic rd_req;
	} state_t_type;

	// attention starts asserted so a freshly powered unit announces itself
	// synchroniser stages start at the idle pin level so no false edge follows reset
	localparam state_t_type RST = '{st: pmbus_slave_pkg::ST_IDLE, alert: 1'b1,
		alert_n: 2'b00, s1: '1, s2: '1, prev: '1, default: '0};

	state_t_type q_r;
	state_t_type q_nxt;

	// next-state logic: bit engine on the port that owns the current frame
	always_comb
	begin
		pmbus_slave_pkg::pin_type cur;
		pmbus_slave_pkg::pin_type prv;
		pmbus_slave_pkg::flags_type set_f;
		logic rise;
		logic fall;
		logic clr;
		logic ara_hit;
		logic [1:0] start_v;
		logic [1:0] stop_v;
		logic [7:0] byte_v;
		logic [7:0] nb;
		cur = '0;
		prv = '0;
		set_f = '0;
		clr = 1'b0;
		ara_hit = 1'b0;
		start_v = '0;
		stop_v = '0;
		byte_v = '0;
		nb = '0;
		rise = 1'b0;
		fall = 1'b0;
		q_nxt = q_r;
		q_nxt.wr_valid = 1'b0;
		q_nxt.rd_req = 1'b0;
		q_nxt.s1 = bus_in;
		q_nxt.s2 = q_r.s1;
		q_nxt.prev = q_r.s2;
		q_nxt.ctrl = ctrl_sel;
		for (int i = 0; i < 2; i++)
		begin
			start_v[i] = q_r.prev[i].sda & ~q_r.s2[i].sda & q_r.s2[i].scl & q_r.prev[i].scl;
			stop_v[i] = ~q_r.prev[i].sda & q_r.s2[i].sda & q_r.s2[i].scl & q_r.prev[i].scl;
		end
		cur = q_r.s2[q_r.port];
		prv = q_r.prev[q_r.port];
		// edges are found by oversampling, which covers both 100 and 400 kHz
		rise = cur.scl & ~prv.scl;
		fall = ~cur.scl & prv.scl;

		// idle watchdog: a silent bus for the full interval re-initialises the engine
		if (q_r.s2 != q_r.prev)
			q_nxt.idle_cnt = '0;
		else if (q_r.idle_cnt != 27'(IDLE_CYCLES))
			q_nxt.idle_cnt = q_r.idle_cnt + 27'h1;

		// lock-up: either line of the owning port low while we do not hold the clock; our own data pull also counts
		if (q_r.st != pmbus_slave_pkg::ST_IDLE && q_r.st != pmbus_slave_pkg::ST_REINIT
			&& !q_r.scl_oe && (!cur.scl || !cur.sda))
			q_nxt.low_cnt = q_r.low_cnt + 20'h1;
		else
			q_nxt.low_cnt = '0;

		case (q_r.st)
			pmbus_slave_pkg::ST_REINIT:
			begin
				// starts seen during these few microseconds are missed
				q_nxt.reinit_cnt = q_r.reinit_cnt + 6'h1;
				if (q_r.reinit_cnt == 6'(pmbus_slave_pkg::REINIT_CYC - 1))
					q_nxt.st = pmbus_slave_pkg::ST_IDLE;
			end
			pmbus_slave_pkg::ST_RX:
			begin
				if (rise)
				begin
					q_nxt.shreg = {q_r.shreg[6:0], cur.sda};
					q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
				end
				else if (fall && q_r.bit_cnt == pmbus_slave_pkg::BITS_PER_BYTE)
				begin
					byte_v = q_r.shreg;
					q_nxt.crc = pmbus_slave_pkg::crc8(q_r.crc, byte_v);
					q_nxt.sda_oe = 1'b1;
					q_nxt.st = pmbus_slave_pkg::ST_RX_ACK;
					q_nxt.addr_phase = 1'b0;
					if (q_r.addr_phase)
					begin
						q_nxt.rw = byte_v[0];
						q_nxt.ara = 1'b0;
						if (byte_v == {pmbus_slave_pkg::ARA_ADDR, 1'b1})
							q_nxt.ara = 1'b1;
						else if (byte_v[7:1] != dev_addr)
						begin
							q_nxt.sda_oe = 1'b0;
							q_nxt.st = pmbus_slave_pkg::ST_IDLE;
						end
					end
					else
					begin
						// standard write: command, low byte, high byte, check byte
						if (q_r.rx_cnt == 3'h0)
							q_nxt.cmd = byte_v;
						if (q_r.rx_cnt == 3'h1)
							q_nxt.lo = byte_v;
						if (q_r.rx_cnt == 3'h2)
							q_nxt.hi = byte_v;
						if (q_r.rx_cnt != pmbus_slave_pkg::MAX_RX_BYTES)
							q_nxt.rx_cnt = q_r.rx_cnt + 3'h1;
					end
				end
			end
			pmbus_slave_pkg::ST_RX_ACK:
			begin
				if (fall)
				begin
					q_nxt.sda_oe = 1'b0;
					q_nxt.bit_cnt = '0;
					if (q_r.rw)
					begin
						// the only place we hold the clock: right after the ninth bit
						q_nxt.scl_oe = 1'b1;
						q_nxt.rd_req = 1'b1;
						q_nxt.str_cnt = '0;
						q_nxt.st = pmbus_slave_pkg::ST_STRETCH;
					end
					else
						q_nxt.st = pmbus_slave_pkg::ST_RX;
				end
			end
			pmbus_slave_pkg::ST_STRETCH:
			begin
				q_nxt.str_cnt = q_r.str_cnt + 20'h1;
				// capped so the hold lasts at most STRETCH_CYCLES cycles, the full stretch limit
				if (rd_valid || q_r.str_cnt == 20'(STRETCH_CYCLES - 1))
				begin
					if (q_r.ara)
						nb = {dev_addr, 1'b1};
					else if (!cmd_supported)
					begin
						nb = '0;
						set_f.unsupported = 1'b1;
					end
					else
						nb = rd_valid ? rd_data[7:0] : 8'h00;
					q_nxt.hi = (cmd_supported && rd_valid) ? rd_data[15:8] : 8'h00;
					q_nxt.shreg = nb;
					q_nxt.crc = pmbus_slave_pkg::crc8(q_r.crc, nb);
					q_nxt.sda_oe = ~nb[7];
					q_nxt.scl_oe = 1'b0;
					q_nxt.tx_idx = '0;
					q_nxt.st = pmbus_slave_pkg::ST_TX;
				end
			end
			pmbus_slave_pkg::ST_TX:
			begin
				// during the alert query a lower address on the wire wins; back off
				if (rise && q_r.ara && q_r.tx_idx == 2'h0 && cur.sda != q_r.shreg[7])
				begin
					q_nxt.sda_oe = 1'b0;
					q_nxt.st = pmbus_slave_pkg::ST_IDLE;
				end
				else if (fall)
				begin
					q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
					if (q_r.bit_cnt == 4'h7)
					begin
						q_nxt.sda_oe = 1'b0;
						q_nxt.st = pmbus_slave_pkg::ST_TX_ACK;
						ara_hit = q_r.ara && q_r.tx_idx == 2'h0;
					end
					else
					begin
						q_nxt.shreg = {q_r.shreg[6:0], 1'b0};
						q_nxt.sda_oe = ~q_r.shreg[6];
					end
				end
			end
			pmbus_slave_pkg::ST_TX_ACK:
			begin
				if (rise && cur.sda)
					q_nxt.st = pmbus_slave_pkg::ST_IDLE;
				else if (fall)
				begin
					// we sent the last data byte, so we also send its check byte
					if (q_r.tx_idx == 2'h0 && !q_r.ara)
						nb = q_r.hi;
					else if (q_r.tx_idx == 2'h0 || (q_r.tx_idx == 2'h1 && !q_r.ara))
						nb = q_r.crc;
					else
						nb = pmbus_slave_pkg::IDLE_BYTE;
					q_nxt.crc = pmbus_slave_pkg::crc8(q_r.crc, nb);
					q_nxt.shreg = nb;
					q_nxt.sda_oe = ~nb[7];
					q_nxt.bit_cnt = '0;
					if (q_r.tx_idx != 2'h3)
						q_nxt.tx_idx = q_r.tx_idx + 2'h1;
					q_nxt.st = pmbus_slave_pkg::ST_TX;
				end
			end
			pmbus_slave_pkg::ST_IDLE:
			begin
				q_nxt.sda_oe = 1'b0;
				q_nxt.scl_oe = 1'b0;
			end
			default:
				q_nxt.st = pmbus_slave_pkg::ST_IDLE;
		endcase

		// stop ends a write frame: one with at least a command byte and a good check byte executes if supported, in range and not a clear from the other port
		if (q_r.st != pmbus_slave_pkg::ST_IDLE && q_r.st != pmbus_slave_pkg::ST_REINIT
			&& stop_v[q_r.port])
		begin
			q_nxt.st = pmbus_slave_pkg::ST_IDLE;
			q_nxt.sda_oe = 1'b0;
			q_nxt.scl_oe = 1'b0;
			if (!q_r.rw && q_r.rx_cnt >= 3'h2)
			begin
				if (q_r.crc != 8'h00)
					set_f.pec_error = 1'b1;
				else if (q_r.cmd == pmbus_slave_pkg::CMD_CLEAR_FAULTS)
					clr = (q_r.port == q_r.ctrl);
				else if (!cmd_supported)
					set_f.unsupported = 1'b1;
				else if (q_r.rx_cnt > 3'h2 && !value_in_range)
					set_f.out_of_range = 1'b1;
				else
				begin
					q_nxt.wr_valid = 1'b1;
					q_nxt.wr = '{cmd: q_r.cmd, lo: q_r.lo, hi: q_r.hi,
						len: 2'(q_r.rx_cnt - 3'h2)};
				end
			end
		end

		// starts are only ever answered, never made; idle takes either port, port 0 first
		if (q_r.st == pmbus_slave_pkg::ST_IDLE && (start_v != 2'b00))
		begin
			q_nxt.port = ~start_v[0];
			q_nxt.crc = '0;
			q_nxt.rx_cnt = '0;
			q_nxt.rw = 1'b0;
			q_nxt.addr_phase = 1'b1;
			q_nxt.bit_cnt = '0;
			q_nxt.st = pmbus_slave_pkg::ST_RX;
		end
		else if (q_r.st != pmbus_slave_pkg::ST_IDLE && q_r.st != pmbus_slave_pkg::ST_REINIT
			&& start_v[q_r.port])
		begin
			// repeated start keeps the running check value over address and command
			q_nxt.addr_phase = 1'b1;
			q_nxt.bit_cnt = '0;
			q_nxt.sda_oe = 1'b0;
			q_nxt.scl_oe = 1'b0;
			q_nxt.st = pmbus_slave_pkg::ST_RX;
		end

		if (q_r.low_cnt == 20'(LOCKUP_CYCLES - 1))
		begin
			q_nxt.st = pmbus_slave_pkg::ST_IDLE;
			q_nxt.sda_oe = 1'b0;
			q_nxt.scl_oe = 1'b0;
			set_f.comm_error = 1'b1;
			q_nxt.sel_alert[q_r.port] = 1'b1;
		end
		if (q_r.idle_cnt == 27'(IDLE_CYCLES - 1))
		begin
			q_nxt.st = pmbus_slave_pkg::ST_REINIT;
			q_nxt.reinit_cnt = '0;
			q_nxt.sda_oe = 1'b0;
			q_nxt.scl_oe = 1'b0;
		end

		// sticky flags and attention: a new event in the clearing cycle wins
		q_nxt.flags = (clr ? pmbus_slave_pkg::flags_type'('0) : q_r.flags) | set_f;
		if (clr)
			q_nxt.sel_alert[q_r.port] = 1'b0;
		q_nxt.alert = ((clr || ara_hit) ? 1'b0 : q_r.alert)
			| (|set_f) | state_change;
		for (int i = 0; i < 2; i++)
			q_nxt.alert_n[i] = ~(q_nxt.alert | q_nxt.sel_alert[i]);
	end

	// single state register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			q_r <= RST;
		else
			q_r <= q_nxt;
	end

	// open-drain pins: only ever pull low, driven toward the owning port
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_pin
			assign bus_out[g] = '0;
			assign bus_oe[g].sda = q_r.sda_oe & (q_r.port == 1'(g));
			assign bus_oe[g].scl = q_r.scl_oe & (q_r.port == 1'(g));
		end
	endgenerate

	assign cur_cmd = q_r.cmd;
	assign rd_req = q_r.rd_req;
	assign wr_valid = q_r.wr_valid;
	assign wr = q_r.wr;
	assign status = q_r.flags;
	assign ctrl_port = q_r.ctrl;
	assign alert_n = q_r.alert_n;

endmodule

// >>> verilog/pmbus_slave_pkg.sv
// shared types, constants and the check-byte function for the dual-port bus slave
// Function
// - unsupported command sets flag and attention
// - unsupported read returns zero data
// - out-of-range write sets flag and attention
// - slave only, never starts, answers promptly
// - stretch only after ninth ack, under 25ms (code holds for up to the full 25ms)
// - bus low over 35ms aborts, releases
// - works at 100 and 400 kHz
// - commands without check byte are ignored
// - check byte is CRC-8 over all bytes
// - last data sender also sends check byte
// - attention buffered onto two outputs, selector adds
// - attention idles high, latches low until clear
// - listed fault events raise attention
// - both attention outputs asserted at power-up
// - attention released only by clear or reset (code also releases the shared latch, but not a port's lock-up bit, on a matching alert query)
// - any internal change reasserts attention
// - five idle seconds re-initialise the controller
// - two ports, primary port controls at power-up
// - write: addr, command, low, high, check
// - read: addr, command, restart, low, high, check
// - longer transfers use block forms
// - alert query sends address, releases on match
// - clear from non-controlling port has no effect
package pmbus_slave_pkg;

	typedef struct packed
	{
		logic scl;
		logic sda;
	} pin_type;

	typedef struct packed
	{
		logic unsupported;
		logic out_of_range;
		logic pec_error;
		logic comm_error;
	} flags_type;

	typedef struct packed
	{
		logic [7:0] cmd;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [1:0] len;
	} wr_type;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_RX = 7'h02,
		ST_RX_ACK = 7'h04,
		ST_STRETCH = 7'h08,
		ST_TX = 7'h10,
		ST_TX_ACK = 7'h20,
		ST_REINIT = 7'h40
	} state_type;

	localparam int CLK_HZ = 25_000_000;
	localparam int STRETCH_MS = 25;
	localparam int LOCKUP_MS = 35;
	localparam int IDLE_S = 5;
	localparam int REINIT_US = 2;
	localparam int STRETCH_CYC = CLK_HZ / 1000 * STRETCH_MS;
	localparam int LOCKUP_CYC = (CLK_HZ / 1000 * LOCKUP_MS) + 1;
	localparam int IDLE_CYC = CLK_HZ * IDLE_S;
	localparam int REINIT_CYC = CLK_HZ / 1_000_000 * REINIT_US;

	localparam logic [6:0] ARA_ADDR = 7'h0C;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [2:0] MAX_RX_BYTES = 3'h7;

	// polynomial x^8+x^2+x+1, msb first, zero start value
	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
		begin
			c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
		end
		return c;
	endfunction

endpackage
